// [src/cpu_exception_entry.sv]
module cpu_exception_entry
	import exc_pkg::*;
#(
	parameter int         NUM_BANKS  = 15,
	parameter logic [7:0] OVF_VECTOR = 8'h0b
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        manual_reset_req,
	input  wire logic        exc_req,
	input  wire logic [2:0]  exc_kind,
	input  wire logic [7:0]  exc_vector,
	input  wire logic [3:0]  exc_level,
	input  wire logic [31:0] pc_in,
	input  wire logic [31:0] sr_in,
	input  wire logic [31:0] sp_in,
	input  wire logic [31:0] save_data,
	output logic      [4:0]  save_idx,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [31:0] mem_addr,
	output logic      [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	input  wire logic        bank_release,
	input  wire logic [4:0]  restore_idx,
	output logic      [31:0] restore_data,
	output logic      [31:0] pc_out,
	output logic      [31:0] sp_out,
	output logic      [31:0] sr_out,
	output logic      [31:0] vbr_out,
	output logic             start_exec,
	output logic             busy,
	output logic             irq
);
	localparam int BA_W = $clog2(NUM_BANKS * SAVE_WORDS);

	seq_state_type       state;
	seq_state_type       next_state;
	exc_kind_type        kind;
	exc_kind_type        next_kind;
	logic [7:0]          vector;
	logic [7:0]          next_vector;
	logic [3:0]          level;
	logic [3:0]          next_level;
	logic                manual;
	logic                next_manual;
	logic                use_bank;
	logic                next_use_bank;
	logic                fallback;
	logic                next_fallback;
	logic [BN_W-1:0]     bank_number;
	logic [BN_W-1:0]     next_bank_number;
	logic                bank_overflow_exception_enable;
	logic                next_bank_overflow_exception_enable;
	logic                bank_en;
	logic                next_bank_en;
	logic [EV_W-1:0]     irq_st;
	logic [EV_W-1:0]     next_irq_st;
	logic [EV_W-1:0]     irq_msk;
	logic [EV_W-1:0]     next_irq_msk;
	logic [EV_W-1:0]     ev;
	logic [EV_W-1:0]     w1c;
	logic [31:0]         next_prdata;
	logic                next_pslverr;
	logic [4:0]          next_save_idx;
	logic                next_mem_req;
	logic                next_mem_we;
	logic [31:0]         next_mem_addr;
	logic [31:0]         next_mem_wdata;
	logic [31:0]         next_pc;
	logic [31:0]         next_sp;
	logic [31:0]         next_sr;
	logic [31:0]         next_vbr;
	logic                next_start;
	logic                next_irq;
	logic                acc_we;
	logic [31:0]         acc_addr;
	logic [31:0]         acc_wdata;
	logic                acc_mem;
	logic                acc_done;
	logic                wr_en;
	logic [31:0]         sp_dec;
	logic [31:0]         save_word;
	logic                banks_full;
	logic                last_word;
	logic                bk_we;
	logic [BA_W-1:0]     bk_waddr;
	logic [BA_W-1:0]     bk_raddr;

	bank_if #(.AW(BA_W)) bank_bus ();

	bank_store #(
		.DEPTH (NUM_BANKS * SAVE_WORDS),
		.AW    (BA_W)
	) u_bank_store (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (bank_bus.store)
	);

	assign bank_bus.we    = bk_we;
	assign bank_bus.waddr = bk_waddr;
	assign bank_bus.wdata = save_word;
	assign bank_bus.raddr = bk_raddr;
	assign restore_data   = bank_bus.rdata;

	// Memory access that the current state needs
	always_comb
	begin
		sp_dec     = sp_out - WORD_BYTES;
		banks_full = (bank_number == BN_W'(NUM_BANKS));
		last_word  = (save_idx == OFFSET_IDX);
		save_word  = last_word ? {22'h0, vector, 2'h0} : save_data;
		acc_mem    = 1'b1;
		acc_we     = 1'b0;
		acc_addr   = 32'h00000000;
		acc_wdata  = 32'h00000000;
		case (state)
			ST_VEC_PC: acc_addr = manual ? MAN_PC_VEC : POR_PC_VEC;
			ST_VEC_SP: acc_addr = manual ? MAN_SP_VEC : POR_SP_VEC;
			ST_PSH_SR:
			begin
				acc_we    = 1'b1;
				acc_addr  = sp_dec;
				acc_wdata = sr_out;
			end
			ST_PSH_PC:
			begin
				acc_we    = 1'b1;
				acc_addr  = sp_dec;
				acc_wdata = pc_out;
			end
			ST_STACK:
			begin
				acc_we    = 1'b1;
				acc_addr  = sp_dec;
				acc_wdata = save_word;
			end
			ST_VEC_H: acc_addr = vbr_out + {22'h0, vector, 2'h0};
			default: acc_mem = 1'b0;
		endcase
		acc_done = mem_req && mem_ack;
		bk_we    = (state == ST_BANK);
		bk_waddr = BA_W'(int'(bank_number) * SAVE_WORDS + int'(save_idx));
		bk_raddr = BA_W'(int'(bank_number - BN_W'(1)) * SAVE_WORDS + int'(restore_idx));
	end

	always_comb
	begin
		next_state       = state;
		next_kind        = kind;
		next_vector      = vector;
		next_level       = level;
		next_manual      = manual;
		next_use_bank    = use_bank;
		next_fallback    = fallback;
		next_bank_number = bank_number;
		next_bank_overflow_exception_enable        = bank_overflow_exception_enable;
		next_bank_en     = bank_en;
		next_irq_msk     = irq_msk;
		next_save_idx    = save_idx;
		next_mem_req     = mem_req;
		next_mem_we      = mem_we;
		next_mem_addr    = mem_addr;
		next_mem_wdata   = mem_wdata;
		next_pc          = pc_out;
		next_sp          = sp_out;
		next_sr          = sr_out;
		next_vbr         = vbr_out;
		next_start       = 1'b0;
		ev               = '0;
		w1c              = '0;

		// Hold each bus request until the memory acknowledges it or a manual reset drops it
		if (acc_mem && !mem_req)
		begin
			next_mem_req   = 1'b1;
			next_mem_we    = acc_we;
			next_mem_addr  = acc_addr;
			next_mem_wdata = acc_wdata;
		end
		else if (acc_done)
			next_mem_req = 1'b0;

		case (state)
			ST_IDLE:
			begin
				if (exc_req)
				begin
					next_kind     = exc_kind_type'(exc_kind);
					next_vector   = exc_vector;
					next_level    = exc_level;
					next_pc       = pc_in;
					next_sp       = sp_in;
					next_sr       = sr_in;
					next_fallback = 1'b0;
					next_use_bank = (exc_kind == K_IRQ) && bank_en;
					next_save_idx = 5'h00;
					if (next_use_bank && banks_full)
					begin
						if (bank_overflow_exception_enable)
						begin
							next_use_bank = 1'b0;
							next_kind     = K_BANKERR;
							next_vector   = OVF_VECTOR;
							ev[EV_OVF]    = 1'b1;
						end
						else
						begin
							next_fallback = 1'b1;
							ev[EV_FALLBK] = 1'b1;
						end
					end
					next_state = ST_PSH_SR;
				end
				else if (bank_release && bank_number != '0)
					next_bank_number = bank_number - BN_W'(1);
			end
			ST_VEC_PC:
				if (acc_done)
				begin
					next_pc    = mem_rdata;
					next_state = ST_VEC_SP;
				end
			ST_VEC_SP:
				if (acc_done)
				begin
					next_sp                 = mem_rdata;
					next_vbr                = VBR_RESET;
					next_sr                 = SR_RESET;
					next_sr[SR_I_LSB +: 4]  = MASK_ALL;
					next_sr[SR_BO_BIT]      = 1'b0;
					next_sr[SR_CS_BIT]      = 1'b0;
					next_bank_number        = '0;
					ev[EV_RESET]            = 1'b1;
					next_state              = ST_DONE;
				end
			ST_PSH_SR:
				if (acc_done)
				begin
					next_sp    = sp_dec;
					next_state = ST_PSH_PC;
				end
			ST_PSH_PC:
				if (acc_done)
				begin
					next_sp = sp_dec;
					if (!use_bank)
						next_state = ST_VEC_H;
					else if (fallback)
						next_state = ST_STACK;
					else
						next_state = ST_BANK;
				end
			ST_BANK:
			begin
				next_save_idx = save_idx + 5'h01;
				if (last_word)
				begin
					next_bank_number = bank_number + BN_W'(1);
					next_state       = ST_VEC_H;
				end
			end
			ST_STACK:
				if (acc_done)
				begin
					next_sp       = sp_dec;
					next_save_idx = save_idx + 5'h01;
					if (last_word)
						next_state = ST_VEC_H;
				end
			ST_VEC_H:
				if (acc_done)
				begin
					next_pc = mem_rdata;
					// Address error and instruction traps keep the mask
					if (kind == K_IRQ || kind == K_NMI || kind == K_UBC)
						next_sr[SR_I_LSB +: 4] = level;
					next_sr[SR_BO_BIT] = banks_full;
					ev[EV_ENTRY]       = 1'b1;
					next_state         = ST_DONE;
				end
			ST_DONE:
			begin
				next_start = 1'b1;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase

		// Manual reset aborts any entry in progress
		if (manual_reset_req)
		begin
			next_manual  = 1'b1;
			next_mem_req = 1'b0;
			next_state   = ST_VEC_PC;
		end

		// APB register writes
		wr_en = psel && penable && pready && pwrite;
		if (wr_en)
			case (paddr)
				CTRL_OFF: next_bank_en = pwdata[0];
				BNCR_OFF: next_bank_overflow_exception_enable = pwdata[BANK_OVERFLOW_EXCEPTION_ENABLE_BIT];
				VBR_OFF:  next_vbr = pwdata;
				IST_OFF:  w1c = pwdata[EV_W-1:0];
				IMSK_OFF: next_irq_msk = pwdata[EV_W-1:0];
				default:  next_bank_overflow_exception_enable = bank_overflow_exception_enable;
			endcase
		next_irq_st = (irq_st & ~w1c) | ev;
		next_irq    = |(next_irq_st & next_irq_msk);

		// Read data is staged in the setup phase
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (psel && !penable)
		begin
			next_prdata = 32'h00000000;
			case (paddr)
				CTRL_OFF:  next_prdata[0] = bank_en;
				BNCR_OFF:
				begin
					next_prdata[BN_W-1:0] = bank_number;
					next_prdata[BANK_OVERFLOW_EXCEPTION_ENABLE_BIT] = bank_overflow_exception_enable;
				end
				VBR_OFF:   next_prdata = vbr_out;
				SR_OFF:    next_prdata = sr_out;
				IST_OFF:   next_prdata[EV_W-1:0] = irq_st;
				IMSK_OFF:  next_prdata[EV_W-1:0] = irq_msk;
				STATE_OFF: next_prdata[8:0] = state;
				default:   next_pslverr = 1'b1;
			endcase
		end
		else if (psel)
			next_pslverr = pslverr;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state       <= ST_VEC_PC;
			kind        <= K_ADDR;
			vector      <= 8'h00;
			level       <= 4'h0;
			manual      <= 1'b0;
			use_bank    <= 1'b0;
			fallback    <= 1'b0;
			bank_number <= '0;
			bank_overflow_exception_enable        <= 1'b0;
			bank_en     <= CTRL_RESET;
			irq_st      <= '0;
			irq_msk     <= '0;
			prdata      <= 32'h00000000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			save_idx    <= 5'h00;
			mem_req     <= 1'b0;
			mem_we      <= 1'b0;
			mem_addr    <= 32'h00000000;
			mem_wdata   <= 32'h00000000;
			pc_out      <= 32'h00000000;
			sp_out      <= 32'h00000000;
			sr_out      <= SR_RESET;
			vbr_out     <= VBR_RESET;
			start_exec  <= 1'b0;
			busy        <= 1'b1;
			irq         <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			kind        <= next_kind;
			vector      <= next_vector;
			level       <= next_level;
			manual      <= next_manual;
			use_bank    <= next_use_bank;
			fallback    <= next_fallback;
			bank_number <= next_bank_number;
			bank_overflow_exception_enable        <= next_bank_overflow_exception_enable;
			bank_en     <= next_bank_en;
			irq_st      <= next_irq_st;
			irq_msk     <= next_irq_msk;
			prdata      <= next_prdata;
			pready      <= 1'b1;
			pslverr     <= next_pslverr;
			save_idx    <= next_save_idx;
			mem_req     <= next_mem_req;
			mem_we      <= next_mem_we;
			mem_addr    <= next_mem_addr;
			mem_wdata   <= next_mem_wdata;
			pc_out      <= next_pc;
			sp_out      <= next_sp;
			sr_out      <= next_sr;
			vbr_out     <= next_vbr;
			start_exec  <= next_start;
			busy        <= (next_state != ST_IDLE);
			irq         <= next_irq;
		end
	end
endmodule

// [src/exc_pkg.sv]
package exc_pkg;

	// Reset vector table slots, VBR reset value and stack word size
	localparam logic [31:0] POR_PC_VEC = 32'h00000000;
	localparam logic [31:0] POR_SP_VEC = 32'h00000004;
	localparam logic [31:0] MAN_PC_VEC = 32'h00000008;
	localparam logic [31:0] MAN_SP_VEC = 32'h0000000c;
	localparam logic [31:0] VBR_RESET  = 32'h00000000;
	localparam logic [31:0] WORD_BYTES = 32'h00000004;

	// status_word layout
	localparam int          SR_I_LSB   = 4;
	localparam int          SR_CS_BIT  = 13;
	localparam int          SR_BO_BIT  = 14;
	localparam logic [3:0]  MASK_ALL   = 4'hf;
	localparam logic [31:0] SR_RESET   = 32'h000000f0;

	// bank_number_control_reg layout
	localparam int          BN_W       = 4;
	localparam int          BANK_OVERFLOW_EXCEPTION_ENABLE_BIT   = 14;

	// Register offsets
	localparam logic [11:0] CTRL_OFF   = 12'h000;
	localparam logic [11:0] BNCR_OFF   = 12'h004;
	localparam logic [11:0] VBR_OFF    = 12'h008;
	localparam logic [11:0] SR_OFF     = 12'h00c;
	localparam logic [11:0] IST_OFF    = 12'h010;
	localparam logic [11:0] IMSK_OFF   = 12'h014;
	localparam logic [11:0] STATE_OFF  = 12'h018;
	localparam logic        CTRL_RESET = 1'b1;

	// Event bits
	localparam int          EV_W       = 4;
	localparam int          EV_RESET   = 0;
	localparam int          EV_ENTRY   = 1;
	localparam int          EV_FALLBK  = 2;
	localparam int          EV_OVF     = 3;

	// Bank frame: 19 core registers plus the vector offset
	localparam int          SAVE_WORDS = 20;
	localparam logic [4:0]  OFFSET_IDX = 5'h13;

	typedef enum logic [2:0] {
		K_ADDR    = 3'h0,
		K_BANKERR = 3'h1,
		K_IRQ     = 3'h2,
		K_NMI     = 3'h3,
		K_UBC     = 3'h4,
		K_INSTR   = 3'h5
	} exc_kind_type;

	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_VEC_PC = 9'h002,
		ST_VEC_SP = 9'h004,
		ST_PSH_SR = 9'h008,
		ST_PSH_PC = 9'h010,
		ST_BANK   = 9'h020,
		ST_STACK  = 9'h040,
		ST_VEC_H  = 9'h080,
		ST_DONE   = 9'h100
	} seq_state_type;

endpackage

// [src/bank_if.sv]
interface bank_if #(parameter int AW = 9);
	logic          we;
	logic [AW-1:0] waddr;
	logic [31:0]   wdata;
	logic [AW-1:0] raddr;
	logic [31:0]   rdata;
	modport ctrl  (output we, waddr, wdata, raddr, input rdata);
	modport store (input we, waddr, wdata, raddr, output rdata);
endinterface

// [src/bank_store.sv]
module bank_store #(
	parameter int DEPTH = 300,
	parameter int AW    = 9
) (
	input  wire logic pclk,
	input  wire logic presetn,
	bank_if.store     bus
);
	logic [31:0] mem [DEPTH];
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rdata = mem[bus.raddr];
	end

	always_ff @(posedge pclk)
	begin
		if (bus.we)
			mem[bus.waddr] <= bus.wdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus.rdata <= 32'h00000000;
		else
			bus.rdata <= next_rdata;
	end
endmodule

// [bench/exc_entry_properties.sv]
module exc_entry_properties
	import exc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        manual_reset_req,
	input wire logic        exc_req,
	input wire logic [2:0]  exc_kind,
	input wire logic [7:0]  exc_vector,
	input wire logic [3:0]  exc_level,
	input wire logic [31:0] pc_in,
	input wire logic [31:0] sr_in,
	input wire logic [31:0] sp_in,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic        mem_ack,
	input wire logic [31:0] pc_out,
	input wire logic [31:0] sp_out,
	input wire logic [31:0] sr_out,
	input wire logic [31:0] vbr_out,
	input wire logic        start_exec,
	input wire logic        busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_ack = mem_req && mem_ack && !mem_we;
	wire take   = exc_req && !busy;
	wire pc_vec = mem_addr == POR_PC_VEC || mem_addr == MAN_PC_VEC;
	wire sp_vec = mem_addr == POR_SP_VEC || mem_addr == MAN_SP_VEC;
	logic [31:0] rst_pc, rst_sp, ent_sp, ent_sr, ent_pc, ent_a;
	logic [3:0]  ent_m, ent_l;
	// Snapshot what the reset, push, mask and handler checks later compare against
	always_ff @(posedge pclk)
	begin
		if (rd_ack && pc_vec)
			rst_pc <= mem_rdata;
		if (rd_ack && sp_vec)
			rst_sp <= mem_rdata;
		if (take)
		begin
			ent_sp <= sp_in;
			ent_sr <= sr_in;
			ent_pc <= pc_in;
			ent_m  <= sr_in[7:4];
			ent_l  <= exc_level;
			ent_a  <= vbr_out + {22'h0, exc_vector, 2'b00};
		end
	end
	AST_POR_PC: assert property ($rose(presetn) |-> ##[1:2] (mem_req && !mem_we &&
		mem_addr == POR_PC_VEC)) else $error("power-on pc fetch missing");
	AST_POR_SP: assert property (rd_ack && mem_addr == POR_PC_VEC |-> ##[2:8] (mem_req
		&& !mem_we && mem_addr == POR_SP_VEC)) else $error("power-on sp fetch missing");
	AST_MAN_PC: assert property (manual_reset_req ##1 !manual_reset_req |-> ##[0:4]
		(mem_req && !mem_we && mem_addr == MAN_PC_VEC)) else $error("manual pc fetch missing");
	AST_RST_STATE: assert property (rd_ack && sp_vec |-> ##[1:8] (start_exec &&
		sp_out == rst_sp && vbr_out == VBR_RESET && sr_out == SR_RESET)) else $error("reset state");
	AST_RST_PC: assert property (rd_ack && sp_vec |-> ##[1:8] (start_exec &&
		pc_out == rst_pc)) else $error("reset start address");
	AST_PUSH_SR: assert property (take |-> ##[1:6] (mem_req && mem_we &&
		mem_addr == ent_sp - 32'h4 && mem_wdata == ent_sr)) else $error("status push");
	AST_PUSH_PC: assert property (mem_req && mem_ack && mem_we && busy &&
		mem_addr == ent_sp - 32'h4 |-> ##[2:8] (mem_req && mem_we &&
		mem_addr == ent_sp - 32'h8 && mem_wdata == ent_pc)) else $error("pc push");
	AST_MASK_KEEP: assert property (take && (exc_kind == K_ADDR || exc_kind == K_INSTR)
		|-> ##[1:60] (start_exec && sr_out[7:4] == ent_m)) else $error("mask changed");
	AST_MASK_SET: assert property (take && (exc_kind == K_NMI || exc_kind == K_UBC)
		|-> ##[1:60] (start_exec && sr_out[7:4] == ent_l)) else $error("mask not set");
	AST_HANDLER: assert property (take && exc_kind != K_IRQ |-> ##[1:60] (mem_req &&
		!mem_we && mem_addr == ent_a)) else $error("handler fetch address");
	AST_HOLD: assert property (mem_req && !mem_ack && !manual_reset_req |=> mem_req &&
		$stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we)) else $error("request moved");
endmodule
bind cpu_exception_entry exc_entry_properties u_props (.*);

// [bench/mem_partner.sv]
module mem_partner
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic      [31:0] mem_rdata,
	output logic             mem_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [0:255];
	logic [1:0]  wait_cnt;
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 32'ha5c30000 + i;
	end
	// Wait states follow address bits 3:2; read data toggles when not acked
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ack <= 1'b0;
			wait_cnt <= 2'h0;
			mem_rdata <= 32'h0;
		end
		else if (!mem_req || mem_ack)
		begin
			mem_ack <= 1'b0;
			wait_cnt <= 2'h0;
			mem_rdata <= ~mem_rdata;
		end
		else if (wait_cnt == mem_addr[3:2])
		begin
			mem_ack <= 1'b1;
			if (mem_we)
				mem[mem_addr[9:2]] <= mem_wdata;
			else
				mem_rdata <= mem[mem_addr[9:2]];
		end
		else
		begin
			wait_cnt <= wait_cnt + 2'h1;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// [bench/test_cpu_exception_entry.sv]
module test_cpu_exception_entry
	import exc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, manual_reset_req, exc_req, bank_release;
	logic        pready, pslverr, mem_req, mem_we, mem_ack, start_exec, busy, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pc_in, sr_in, sp_in, save_data, mem_addr, mem_wdata;
	logic [31:0] mem_rdata, restore_data, pc_out, sp_out, sr_out, vbr_out, rd;
	logic [2:0]  exc_kind;
	logic [7:0]  exc_vector, k;
	logic [3:0]  exc_level;
	logic [4:0]  save_idx, restore_idx;
	logic [63:0] exp_wr[$];
	logic [31:0] exp_pc[$];
	int          errors, cmp_count, seed;
	assign save_data = 32'h5ee00000 | {27'h0, save_idx};
	cpu_exception_entry #(.OVF_VECTOR(8'h0b)) u_dut (.*);
	mem_partner u_mem (.*);
	initial
	begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task wrap_up;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (!pready && n < 50);
		if (!pready)
		begin
			errors++;
			wrap_up;
		end
		rd = prdata;
		chk(pslverr, err, "slave error");
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wait_idle;
		int n;
		n = 0;
		@(negedge pclk);
		while (busy !== 1'b0 && n < 600)
		begin
			@(negedge pclk);
			n++;
		end
		if (busy !== 1'b0)
		begin
			errors++;
			wrap_up;
		end
		@(posedge pclk);
	endtask
	task exc(input logic [2:0] kd, input logic [7:0] v, input logic [7:0] hv, input logic fb);
		logic [31:0] p, s;
		p = $random(seed);
		s = $random(seed);
		exp_wr.push_back({32'h2fc, s});
		exp_wr.push_back({32'h2f8, p});
		for (int i = 0; i < 20 && fb; i++)
			exp_wr.push_back({32'h2f4 - 4 * i, i == 19 ? {22'h0, v, 2'b00} : 32'h5ee00000 + i});
		exp_pc.push_back(32'ha5c30000 + hv);
		exc_req <= 1;
		exc_kind <= kd;
		exc_vector <= v;
		exc_level <= v[3:0];
		pc_in <= p;
		sr_in <= s;
		sp_in <= 32'h300;
		@(posedge pclk) exc_req <= 0;
		wait_idle;
		chk(sr_out[7:4], (kd >= 2 && kd <= 4 && hv == v) ? v[3:0] : s[7:4], "mask");
	endtask
	// Each completed write and each start is matched against the oldest note
	always @(posedge pclk)
	begin
		if (mem_req && mem_ack && mem_we)
			chk({mem_addr, mem_wdata}, exp_wr.size() ? exp_wr.pop_front() : 'x, "push");
		if (start_exec)
			chk(pc_out, exp_pc.size() ? exp_pc.pop_front() : 'x, "start pc");
	end
	initial
	begin
		seed = 32'h70fc83f4;
		{presetn, psel, penable, pwrite, manual_reset_req, exc_req, bank_release} = 0;
		{paddr, pwdata, pc_in, sr_in, sp_in, exc_kind, exc_vector, exc_level, restore_idx} = 0;
		exp_pc.push_back(32'ha5c30000);
		repeat (6) @(posedge pclk);
		presetn <= 1;
		wait_idle;
		chk(sp_out, 32'ha5c30001, "reset sp");
		chk(vbr_out, VBR_RESET, "vbr");
		chk(sr_out, SR_RESET, "reset sr");
		chk(irq, 0, "irq masked");
		apb(1, IMSK_OFF, 1, 0);
		repeat (2) @(posedge pclk);
		chk(irq, 1, "irq raised");
		apb(1, IST_OFF, 1, 0);
		repeat (2) @(posedge pclk);
		chk(irq, 0, "irq cleared");
		apb(0, 12'h020, 0, 1);
		chk(rd, 0, "unmapped read");
		apb(0, CTRL_OFF, 0, 0);
		chk(rd[0], CTRL_RESET, "ctrl reset");
		apb(0, BNCR_OFF, 0, 0);
		chk(rd, 0, "bank control reset");
		for (k = 0; k < 6; k++)
			exc(k[2:0], 8'h20 + k, 8'h20 + k, 0);
		apb(0, BNCR_OFF, 0, 0);
		chk(rd[3:0], 1, "one bank used");
		for (k = 0; k < 14; k++)
			exc(K_IRQ, 8'h28, 8'h28, 0);
		exc(K_IRQ, 8'h29, 8'h29, 1);
		chk(sr_out[SR_BO_BIT], 1, "banks full flag");
		apb(0, IST_OFF, 0, 0);
		chk(rd[EV_FALLBK], 1, "fallback event");
		apb(1, BNCR_OFF, 32'h4000, 0);
		exc(K_IRQ, 8'h2a, 8'h0b, 0);
		apb(0, IST_OFF, 0, 0);
		chk(rd[EV_OVF], 1, "overflow event");
		// Top bank holds the last banked frame; its offset slot carries that frame's vector shifted left by two
		restore_idx <= 5'h13;
		repeat (2) @(posedge pclk);
		chk(restore_data, 32'h000000a0, "bank offset slot");
		bank_release <= 1;
		@(posedge pclk) bank_release <= 0;
		apb(0, BNCR_OFF, 0, 0);
		chk(rd[3:0], 14, "bank released");
		apb(1, VBR_OFF, 32'h40, 0);
		exc(K_ADDR, 8'h21, 8'h31, 0);
		exp_pc.push_back(32'ha5c30002);
		manual_reset_req <= 1;
		@(posedge pclk) manual_reset_req <= 0;
		wait_idle;
		chk(sp_out, 32'ha5c30003, "manual sp");
		chk(sr_out, SR_RESET, "manual sr");
		chk(vbr_out, VBR_RESET, "manual vbr");
		apb(0, BNCR_OFF, 0, 0);
		chk(rd[3:0], 0, "bank number cleared");
		wrap_up;
	end
endmodule
